//--- shared/aper_pkg.sv
package aper_pkg;

    // =========================================================
    // data word and check masks
    // =========================================================
    localparam int unsigned DATA_W = 25;
    // bit k-1 carries data input k
    localparam logic [24:0] MASK_SINGLE = 25'h1FFFFB6;
    localparam logic [24:0] MASK_PAIR_A = 25'h0003FB6;
    localparam logic [24:0] MASK_PAIR_B = 25'h0001FBF;

    // =========================================================
    // timing and reset values
    // =========================================================
    localparam int unsigned ERR_HOLD_CYCLES = 2;
    localparam logic [1:0] HOLD_LOAD = 2'(ERR_HOLD_CYCLES - 1);
    localparam logic [1:0] HOLD_RST = 2'h0;
    localparam logic ERR_N_RST = 1'b1;
    localparam logic PPO_RST = 1'b0;
    localparam int unsigned SYNC_STAGES = 3;

    // =========================================================
    // strap carrier and decoded mode
    // =========================================================
    typedef struct packed {
        logic strap_hi;
        logic strap_lo;
    } aper_cfg_t;

    localparam aper_cfg_t CFG_RST = 2'h0;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_PAIR_A = 2'b10,
        MODE_ODD = 2'b01,
        MODE_PAIR_B = 2'b11
    } aper_mode_t;

endpackage : aper_pkg

//--- verilog/aper_parity_tree.sv
`timescale 1ns/1ps

module aper_parity_tree
(
    // word and selection
    input wire logic [aper_pkg::DATA_W-1:0] data_i,
    input wire logic [aper_pkg::DATA_W-1:0] mask_i,
    input wire logic par_bit_i,
    // result: high when the ones count is odd
    output logic odd_o
);
    import aper_pkg::*;

    logic [DATA_W-1:0] sel_w;

    // =========================================================
    // per-bit selection
    // =========================================================
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++)
        begin : g_sel
            assign sel_w[gi] = data_i[gi] & mask_i[gi];
        end
    endgenerate

    // even parity: an odd total means a mismatch
    assign odd_o = (^sel_w) ^ par_bit_i;

endmodule : aper_parity_tree

//--- verilog/aper_top.sv
`timescale 1ns/1ps

// Summary of operation
// [R01] controller holds inputs low after reset release
// [R02] standalone: error generated two edges after capture
// [R03] pair first: error generated one edge after capture
// [R04] error held low two cycles, reset clears
// [R05] inputs stay at valid levels entering reset
// [R06] pair second: parity from partial output, two edges
// [R07] even parity over selected data plus parity
module aper_top
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // registered inputs from the controller
    input wire logic [aper_pkg::DATA_W-1:0] data_i,
    input wire logic parity_in_i,
    // configuration straps (pins)
    input wire logic config_strap_lo_i,
    input wire logic config_strap_hi_i,
    // open-drain error pin, active low
    output logic parity_error_n_o,
    output logic parity_error_oe_o,
    // cascade output to a second device
    output logic partial_parity_out_o
);
    import aper_pkg::*;

    aper_cfg_t sync1_ff, sync2_ff, sync3_ff, cfg_ff;
    aper_mode_t mode_w;
    logic [DATA_W-1:0] mask_w;
    logic [DATA_W-1:0] data_ff, data_dly_ff;
    logic par_ff, late_par_w;
    logic odd_early_w, odd_late_w, odd_sel_w;
    logic err_n_ff, ppo_ff;
    logic [1:0] hold_ff;

    // =========================================================
    // strap synchroniser
    // =========================================================
    // straps come from pins; only stage two and three are compared
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sync1_ff <= CFG_RST;
            sync2_ff <= CFG_RST;
            sync3_ff <= CFG_RST;
        end
        else
        begin
            sync1_ff <= '{strap_hi: config_strap_hi_i, strap_lo: config_strap_lo_i};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // a strap change counts once stages two and three agree
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cfg_ff <= CFG_RST;
        end
        else if (sync2_ff == sync3_ff)
        begin
            cfg_ff <= sync3_ff;
        end
    end

    // =========================================================
    // mode decode and check mask
    // =========================================================
    // the undocumented strap pair falls back to standalone checking
    always_comb
    begin
        // enum codes read high strap first, as the carrier packs them
        mode_w = aper_mode_t'({cfg_ff.strap_hi, cfg_ff.strap_lo});
        unique case (mode_w)
            MODE_PAIR_A: mask_w = MASK_PAIR_A;
            MODE_PAIR_B: mask_w = MASK_PAIR_B;
            MODE_SINGLE: mask_w = MASK_SINGLE;
            MODE_ODD: mask_w = MASK_SINGLE;
        endcase
    end

    // =========================================================
    // capture pipeline
    // =========================================================
    // parity arrives one cycle after its data word
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            data_ff <= '0;
            data_dly_ff <= '0;
            par_ff <= 1'b0;
        end
        else
        begin
            data_ff <= data_i;
            data_dly_ff <= data_ff;
            par_ff <= parity_in_i;
        end
    end

    // first of pair checks against the live parity input
    aper_parity_tree u_tree_early
    (
        .data_i (data_ff),
        .mask_i (mask_w),
        .par_bit_i (parity_in_i),
        .odd_o (odd_early_w)
    );

    // the second of a pair gets the first one's partial output an edge
    // after the first device took its own bit, so it checks the live pin
    assign late_par_w = (mode_w == MODE_PAIR_B) ? parity_in_i : par_ff; // R06

    // standalone and second of pair check one stage later
    aper_parity_tree u_tree_late
    (
        .data_i (data_dly_ff),
        .mask_i (mask_w),
        .par_bit_i (late_par_w),
        .odd_o (odd_late_w)
    );

    assign odd_sel_w = (mode_w == MODE_PAIR_A) ? odd_early_w : odd_late_w; // R02 R03 R06

    // =========================================================
    // partial parity cascade
    // =========================================================
    // on the second device parity_in_i is the first one's output
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ppo_ff <= PPO_RST;
        end
        else
        begin
            ppo_ff <= odd_sel_w; // R06
        end
    end

    // =========================================================
    // latched error output
    // =========================================================
    // a new error always wins over the end of a hold
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            err_n_ff <= ERR_N_RST;
            hold_ff <= HOLD_RST;
        end
        else if (odd_sel_w)
        begin
            err_n_ff <= 1'b0; // R07
            hold_ff <= HOLD_LOAD; // R04
        end
        else if (hold_ff != HOLD_RST)
        begin
            hold_ff <= hold_ff - 2'h1; // R04
        end
        else
        begin
            err_n_ff <= 1'b1; // R07
        end
    end

    assign parity_error_n_o = err_n_ff;
    assign parity_error_oe_o = ~err_n_ff; // pin only pulled low
    assign partial_parity_out_o = ppo_ff;

    // =========================================================
    // checks
    // =========================================================
    // independent parity of each word as it is captured
    logic chk_dpar_ff;
    logic chk_dpar_dly_ff;
    logic chk_bad_w;
    logic chk_bad_b_w;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            chk_dpar_ff <= 1'b0;
            chk_dpar_dly_ff <= 1'b0;
        end
        else
        begin
            chk_dpar_ff <= ^(data_i & mask_w);
            chk_dpar_dly_ff <= chk_dpar_ff;
        end
    end

    assign chk_bad_w = chk_dpar_ff ^ parity_in_i;
    // cascaded parity lands one edge later than the controller's bit
    assign chk_bad_b_w = chk_dpar_dly_ff ^ parity_in_i;

    sequence s_single_steady;
        (mode_w == MODE_SINGLE) ##1 (mode_w == MODE_SINGLE);
    endsequence

    sequence s_pair_b_steady;
        (mode_w == MODE_PAIR_B) ##1 (mode_w == MODE_PAIR_B);
    endsequence

    property p_single_latency;
        @(posedge clk_i) disable iff (sys_rst_i)
        (chk_bad_w && mode_w == MODE_SINGLE) ##0 s_single_steady |=> !parity_error_n_o;
    endproperty
    a_single_latency: assert property (p_single_latency) // R02
        else $error("standalone error not low two edges after capture");

    property p_pair_a_latency;
        @(posedge clk_i) disable iff (sys_rst_i)
        (chk_bad_w && mode_w == MODE_PAIR_A) |=> (!parity_error_n_o && partial_parity_out_o);
    endproperty
    a_pair_a_latency: assert property (p_pair_a_latency) // R03
        else $error("first of pair error not low one edge after capture");

    property p_pair_b_latency;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_pair_b_steady ##1 (chk_bad_b_w && mode_w == MODE_PAIR_B) |=> !parity_error_n_o;
    endproperty
    a_pair_b_latency: assert property (p_pair_b_latency) // R06
        else $error("second of pair error not low two edges after capture");

    property p_hold_two;
        @(posedge clk_i) disable iff (sys_rst_i)
        $fell(parity_error_n_o) |=> !parity_error_n_o;
    endproperty
    a_hold_two: assert property (p_hold_two) // R04
        else $error("error released after fewer than two cycles");

    property p_release_cause;
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(parity_error_n_o) |-> ($past(hold_ff) == HOLD_RST && !$past(odd_sel_w));
    endproperty
    a_release_cause: assert property (p_release_cause) // R07
        else $error("error released while hold active or error present");

    property p_pair_a_ppo;
        @(posedge clk_i) disable iff (sys_rst_i)
        (mode_w == MODE_PAIR_A) ##1 (mode_w == MODE_PAIR_A)
        |-> partial_parity_out_o == $past(chk_bad_w);
    endproperty
    a_pair_a_ppo: assert property (p_pair_a_ppo) // R06
        else $error("partial parity output does not match captured word");

endmodule : aper_top

//--- bench/aper_ctrl_model.sv
`timescale 1ns/1ps

// =====================================
// controller model: word now, parity one edge later, two edges later with late_i
// =====================================
module aper_ctrl_model
(
    // clock
    input wire logic clk_i,
    // word, checked bits, error request, cascade timing
    input wire logic [aper_pkg::DATA_W-1:0] word_i,
    input wire logic [aper_pkg::DATA_W-1:0] mask_i,
    input wire logic bad_i,
    input wire logic late_i,
    // toward the buffer
    output logic [aper_pkg::DATA_W-1:0] data_o,
    output logic parity_o
);
    import aper_pkg::*;
    logic par_dly = 1'b0;
    // the word goes out as soon as the bench sets it
    assign data_o = word_i;
    // even parity a cycle late; it is only wrong when the bench asks
    // behind a first device the bit is its partial output, an edge later
    initial parity_o = 1'b0;
    always @(posedge clk_i)
    begin
        par_dly <= (^(word_i & mask_i)) ^ bad_i;
        parity_o <= #2 late_i ? par_dly : ((^(word_i & mask_i)) ^ bad_i);
    end
endmodule : aper_ctrl_model

//--- bench/aper_top_tb_top.sv
`timescale 1ns/1ps

module aper_top_tb_top;
    import aper_pkg::*;
    // =====================================
    // signals and notes
    // =====================================
    typedef struct {int unsigned cyc; logic e;} aper_note_t;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [DATA_W-1:0] word = '0;
    logic [DATA_W-1:0] mask = MASK_SINGLE;
    logic bad = 1'b0;
    logic late = 1'b0;
    logic lo = 1'b0;
    logic hi = 1'b0;
    logic [DATA_W-1:0] data;
    logic par, err_n, err_oe, partial_parity_out;
    logic prev_e = 1'b0;
    logic e;
    int unsigned cyc = 0, lat = 2, n_errors = 0, checks_done = 0;
    aper_note_t q[$];
    aper_note_t n;
    logic [1:0] straps[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [DATA_W-1:0] masks[4] = '{MASK_SINGLE, MASK_PAIR_A, MASK_PAIR_B, MASK_SINGLE};

    // =====================================
    // instances
    // =====================================
    aper_ctrl_model aper_ctrl_model_i (.clk_i(clk_i), .word_i(word), .mask_i(mask),
        .bad_i(bad), .late_i(late), .data_o(data), .parity_o(par));
    aper_top aper_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .data_i(data),
        .parity_in_i(par), .config_strap_lo_i(lo), .config_strap_hi_i(hi),
        .parity_error_n_o(err_n), .parity_error_oe_o(err_oe),
        .partial_parity_out_o(partial_parity_out));

    // =====================================
    // clock and edge count
    // =====================================
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;

    // =====================================
    // tasks
    // =====================================
    task automatic check(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : check

    task automatic test_done();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // straps change only under reset, since they need settling edges
    task automatic do_reset(input logic [1:0] s);
        @(posedge clk_i);
        #2;
        sys_rst_i = 1'b1;
        word = '0;
        bad = 1'b0;
        {lo, hi} = s;
        repeat (5) @(posedge clk_i);
        #2;
        sys_rst_i = 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : do_reset

    // the note holds the edge after which the result must show
    task automatic send(input logic [DATA_W-1:0] w, input logic b);
        @(posedge clk_i);
        #2;
        word = w;
        bad = b;
        q.push_back('{cyc + 1 + lat, b});
    endtask : send

    // =====================================
    // result watcher: err held while this or the last cycle erred
    // =====================================
    always @(negedge clk_i)
    begin
        if (sys_rst_i)
        begin
            q.delete();
            prev_e = 1'b0;
        end
        else
        begin
            e = 1'b0;
            if (q.size() > 0 && q[0].cyc == cyc)
            begin
                n = q.pop_front();
                e = n.e;
            end
            check(partial_parity_out, e, "ppo");
            check(err_n, ~(e | prev_e), "err_n");
            check(err_oe, e | prev_e, "oe");
            prev_e = e;
        end
    end

    // =====================================
    // main sequence: every strap setting, then reset during a hold
    // =====================================
    initial
    begin
        void'($urandom(54));
        for (int m = 0; m < 4; m++)
        begin
            mask = masks[m];
            lat = (m == 1) ? 1 : 2;
            late = (m == 2);
            do_reset(straps[m]);
            repeat (40) send(DATA_W'($urandom), ($urandom % 3) == 0);
            send('1, 1'b1);
            send('1, 1'b1);
            send('1, 1'b0);
            repeat (4) send('0, 1'b0);
        end
        mask = MASK_SINGLE;
        lat = 2;
        late = 1'b0;
        do_reset(2'h0);
        send('0, 1'b1);
        send('0, 1'b0);
        repeat (2) @(posedge clk_i);
        #2;
        check(err_n, 1'b0, "err before reset");
        sys_rst_i = 1'b1;
        #1;
        check(err_n, 1'b1, "err cleared");
        check(err_oe, 1'b0, "oe cleared");
        test_done();
    end

    // watchdog: the whole run needs well under 2000 cycles
    initial
    begin
        #(25 * 2000);
        n_errors++;
        test_done();
    end
endmodule : aper_top_tb_top
